// [adc_clock_divider.sv]
`timescale 1ns/10ps
module adc_clock_divider
    import adc_touch_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);

    logic [WIDTH-1:0] count_reg;

    // one pulse every divisor+1 clocks; held cleared while disabled
    always_ff @(posedge clk)
    begin
        if (rst || !enable)
        begin
            count_reg <= '0;
            tick      <= 1'b0;
        end
        else if (count_reg == divisor)
        begin
            count_reg <= '0;
            tick      <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
            tick      <= 1'b0;
        end
    end

endmodule : adc_clock_divider

// [adc_panel_model.sv]
`timescale 1ns/10ps
module adc_panel_model
    import adc_touch_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                pen_down,
    input  wire logic [2:0]          channel,
    output logic                     ext_clk,
    output logic                     stylus_up,
    output logic      [RESULT_W-1:0] result
);
    logic [1:0] div_cnt;
    initial div_cnt = 2'h0;
    // slow timing clock at a quarter of the core rate
    always @(posedge clk) div_cnt <= div_cnt + 2'h1;
    assign ext_clk   = div_cnt[1];
    assign stylus_up = ~pen_down;
    // each input reads back its own index, so a wrong mux shows in data
    assign result    = {channel, 7'h2B};
endmodule : adc_panel_model

// [adc_touch_panel_control.sv]
`timescale 1ns/10ps
// Function
// R1 - read-only bit 15 of control: zero while converting, one when done
// R2 - divider runs only with bit 14 set; divide value bits 13:6, reset ff
// R3 - software keeps converter clock below one fifth of core clock
// R4 - bits 5:3 pick one of eight inputs; 101 is Y-plus, 111 X-plus
// R5 - bit 2 selects standby, resets to one
// R6 - with start-on-read set, each result read launches a conversion
// R7 - start bit begins conversion, self-clears, ignored under start-on-read
// R8 - bits 7 and 5 drive Y-minus and X-minus ground switches, reset zero
// R9 - bits 6 and 4 drive active-low Y-plus and X-plus supply, reset one
// R10 - bit 3 zero enables X-plus pull-up, one disables, resets one
// R11 - touch bit 2 converts X then Y automatically, else single conversion
// R12 - bits 1:0 select none, X, Y or wait for stylus
// R13 - after auto sequence pointer stays at Y; software rewrites 01
// R14 - software sets auto bit again after each start-on-read conversion
// R15 - software enables pull-up before entering wait-for-stylus
// R16 - 16-bit delay count sets wait before each conversion, reset 00ff
// R17 - stylus down raises interrupt, repeated at the delay interval
// R18 - software never writes zero delay
// R19 - wait logic times on external clock, conversion on core clock
// R20 - X result shows stylus state, auto bit and selector in 15:12
// R21 - X result or single result sits in bits 9:0
// R22 - X result bit 14 mirrors the auto sequencing indication
// R23 - converter clock is core clock over divide value plus one
// R24 - one conversion takes five converter clock cycles
// R25 - standby halts conversion; results keep their last values
// R26 - finished X or Y position conversion raises interrupt request
// R27 - done flag returns to zero when a new conversion launches
module adc_touch_panel_control
    import adc_touch_pkg::*;
(
    input  wire logic                CORE_CLK,
    input  wire logic                RST,
    input  wire logic [31:0]         PADDR,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                EXTERNAL_CLOCK_INPUT,
    input  wire logic                STYLUS_UP,
    input  wire logic [RESULT_W-1:0] ADC_RESULT,
    output logic                     ADC_CLK_TICK,
    output logic      [2:0]          ADC_CHANNEL,
    output logic                     ADC_CONVERTING,
    output logic                     ADC_STANDBY,
    output panel_switch_t            PANEL_SWITCH,
    output logic      [RESULT_W-1:0] Y_RESULT,
    output logic                     ADC_IRQ
);

    conv_state_t         state_reg;
    logic                done_reg;
    logic                div_en_reg;
    logic [7:0]          div_val_reg;
    logic [2:0]          chan_reg;
    logic                standby_reg;
    logic                read_start_reg;
    logic                start_reg;
    logic [7:3]          sw_reg;
    logic                auto_reg;
    meas_sel_t           sel_reg;
    logic [15:0]         delay_reg;
    logic [RESULT_W-1:0] x_data_reg;
    logic [RESULT_W-1:0] y_data_reg;
    logic                read_pend_reg;
    logic                ptr_y_reg;
    logic                auto_run_reg;
    logic                pos_run_reg;
    logic [15:0]         dly_cnt_reg;
    logic [2:0]          conv_cnt_reg;
    logic [15:0]         pen_cnt_reg;
    logic                irq_reg;
    logic [2:0]          chan_out_reg;
    logic [31:0]         prdata_reg;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_s3;
    logic                pen_s1;
    logic                pen_s2;
    logic                pen_s3;
    logic [RESULT_W-1:0] adc_s1;
    logic [RESULT_W-1:0] adc_s2;

    logic                conv_tick;
    logic                ext_tick;
    logic                setup;
    logic                access;
    logic                hit;
    logic                wr_ctrl;
    logic                wr_sw;
    logic                wr_dly;
    logic                rd_x;
    logic                launch;
    logic                capture;
    logic                finish;
    logic                end_auto;
    logic                pen_down_edge;
    logic                pen_repeat;
    logic [31:0]         rdata_next;

    // pins from outside the core clock domain pass two flops first
    always_ff @(posedge CORE_CLK)
    begin
        ext_s1 <= EXTERNAL_CLOCK_INPUT;
        ext_s2 <= ext_s1;
        ext_s3 <= ext_s2;
        pen_s1 <= STYLUS_UP;
        pen_s2 <= pen_s1;
        pen_s3 <= pen_s2;
        adc_s1 <= ADC_RESULT;
        adc_s2 <= adc_s1;
    end

    // delay and stylus interval time on the external clock edges
    assign ext_tick      = ext_s2 && !ext_s3; // see R19
    assign pen_down_edge = !pen_s2 && pen_s3 && (sel_reg == SEL_WAIT);

    adc_clock_divider #(
        .WIDTH   (8)
    ) u_divider (
        .clk     (CORE_CLK),
        .rst     (RST),
        .enable  (div_en_reg),           // see R2
        .divisor (div_val_reg),          // see R23
        .tick    (conv_tick)
    );

    // zero-wait slave; data is latched in the setup cycle
    assign setup   = PSEL && !PENABLE;
    assign access  = PSEL && PENABLE;
    assign hit     = (PADDR == CONVERTER_CONTROL_ADDR)
                  || (PADDR == PANEL_SWITCH_CONTROL_ADDR)
                  || (PADDR == CONVERSION_DELAY_ADDR)
                  || (PADDR == X_RESULT_ADDR);
    assign wr_ctrl = access && PWRITE && (PADDR == CONVERTER_CONTROL_ADDR);
    assign wr_sw   = access && PWRITE && (PADDR == PANEL_SWITCH_CONTROL_ADDR);
    assign wr_dly  = access && PWRITE && (PADDR == CONVERSION_DELAY_ADDR);
    assign rd_x    = access && !PWRITE && (PADDR == X_RESULT_ADDR);
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !hit;
    assign PRDATA  = prdata_reg;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (PADDR)
            CONVERTER_CONTROL_ADDR:
            begin
                rdata_next[DONE_BIT]                = done_reg; // see R1
                rdata_next[DIV_EN_BIT]              = div_en_reg;
                rdata_next[DIV_VAL_MSB:DIV_VAL_LSB] = div_val_reg;
                rdata_next[CHAN_MSB:CHAN_LSB]       = chan_reg;
                rdata_next[STANDBY_BIT]             = standby_reg;
                rdata_next[READ_START_BIT]          = read_start_reg;
                rdata_next[START_BIT]               = start_reg;
            end
            PANEL_SWITCH_CONTROL_ADDR:
            begin
                rdata_next[YM_BIT:PULLUP_BIT]       = sw_reg;
                rdata_next[AUTO_BIT]                = auto_reg;
                rdata_next[SEL_MSB:SEL_LSB]         = sel_reg;
            end
            CONVERSION_DELAY_ADDR:
            begin
                rdata_next[15:0]                    = delay_reg;
            end
            X_RESULT_ADDR:
            begin
                rdata_next[XR_STYLUS_BIT]           = pen_s2; // see R20
                rdata_next[XR_AUTO_BIT]             = auto_reg; // see R22
                rdata_next[XR_SEL_MSB:XR_SEL_LSB]   = sel_reg; // see R20
                rdata_next[XR_DATA_MSB:0]           = x_data_reg; // see R21
            end
            default:
            begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            prdata_reg <= 32'h0000_0000;
        else if (setup)
            prdata_reg <= rdata_next;
    end

    // control register fields
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            div_en_reg     <= CONTROL_RESET[DIV_EN_BIT];
            div_val_reg    <= CONTROL_RESET[DIV_VAL_MSB:DIV_VAL_LSB];
            chan_reg       <= CONTROL_RESET[CHAN_MSB:CHAN_LSB];
            standby_reg    <= CONTROL_RESET[STANDBY_BIT]; // see R5
            read_start_reg <= CONTROL_RESET[READ_START_BIT];
        end
        else if (wr_ctrl)
        begin
            div_en_reg     <= PWDATA[DIV_EN_BIT];
            div_val_reg    <= PWDATA[DIV_VAL_MSB:DIV_VAL_LSB];
            chan_reg       <= PWDATA[CHAN_MSB:CHAN_LSB]; // see R4
            standby_reg    <= PWDATA[STANDBY_BIT];
            read_start_reg <= PWDATA[READ_START_BIT];
        end
    end

    // a fresh write of one wins over the self-clear at start-up
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            start_reg <= CONTROL_RESET[START_BIT];
        else if (wr_ctrl)
            start_reg <= PWDATA[START_BIT];
        else if (launch)
            start_reg <= 1'b0; // see R7
    end

    // a result read under start-on-read is held until the core can take it
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            read_pend_reg <= 1'b0;
        else if (rd_x && read_start_reg)
            read_pend_reg <= 1'b1; // see R6
        else if (launch || !read_start_reg)
            read_pend_reg <= 1'b0;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            sw_reg <= SWITCH_RESET[YM_BIT:PULLUP_BIT];
        else if (wr_sw)
            sw_reg <= PWDATA[YM_BIT:PULLUP_BIT];
    end

    // software writes take priority over the end-of-sequence update
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            auto_reg <= SWITCH_RESET[AUTO_BIT];
            sel_reg  <= meas_sel_t'(SWITCH_RESET[SEL_MSB:SEL_LSB]);
        end
        else if (wr_sw)
        begin
            auto_reg <= PWDATA[AUTO_BIT]; // see R11
            sel_reg  <= meas_sel_t'(PWDATA[SEL_MSB:SEL_LSB]); // see R12
        end
        else if (end_auto)
        begin
            auto_reg <= 1'b0; // see R14
            sel_reg  <= SEL_Y; // see R13
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            delay_reg <= DELAY_RESET; // see R16
        else if (wr_dly)
            delay_reg <= PWDATA[15:0];
    end

    // conversion sequencer
    assign launch   = (state_reg == ST_IDLE) && !standby_reg
                   && (sel_reg != SEL_WAIT)
                   && (read_start_reg ? read_pend_reg : start_reg); // see R7
    assign capture  = (state_reg == ST_CONV) && !standby_reg && conv_tick
                   && (conv_cnt_reg == CONV_CYCLES - 3'h1); // see R24
    assign finish   = capture && !(auto_run_reg && !ptr_y_reg);
    assign end_auto = finish && auto_run_reg;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            state_reg    <= ST_IDLE;
            ptr_y_reg    <= 1'b0;
            auto_run_reg <= 1'b0;
            pos_run_reg  <= 1'b0;
            dly_cnt_reg  <= 16'h0000;
            conv_cnt_reg <= 3'h0;
        end
        else if (standby_reg && state_reg != ST_IDLE)
            state_reg <= ST_IDLE; // see R25
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (launch)
                    begin
                        state_reg    <= ST_DELAY;
                        ptr_y_reg    <= (sel_reg == SEL_Y) && !auto_reg;
                        auto_run_reg <= auto_reg; // see R11
                        pos_run_reg  <= auto_reg || (sel_reg != SEL_NONE);
                        dly_cnt_reg  <= 16'h0000;
                    end
                end
                ST_DELAY:
                begin
                    if (ext_tick)
                    begin
                        dly_cnt_reg <= dly_cnt_reg + 16'h0001;
                        if (dly_cnt_reg + 16'h0001 == delay_reg) // see R16
                        begin
                            state_reg    <= ST_CONV;
                            conv_cnt_reg <= 3'h0;
                        end
                    end
                end
                ST_CONV:
                begin
                    if (capture && auto_run_reg && !ptr_y_reg)
                    begin
                        state_reg   <= ST_DELAY;
                        ptr_y_reg   <= 1'b1;
                        dly_cnt_reg <= 16'h0000;
                    end
                    else if (capture)
                        state_reg <= ST_IDLE;
                    else if (conv_tick)
                        conv_cnt_reg <= conv_cnt_reg + 3'h1;
                end
            endcase
        end
    end

    // results only change at a capture, so standby keeps them
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            x_data_reg <= '0;
            y_data_reg <= '0;
        end
        else if (capture && ptr_y_reg)
            y_data_reg <= adc_s2;
        else if (capture)
            x_data_reg <= adc_s2; // see R21
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            done_reg <= CONTROL_RESET[DONE_BIT];
        else if (launch)
            done_reg <= 1'b0; // see R27
        else if (finish)
            done_reg <= 1'b1; // see R1
    end

    // stylus interval counter; a zero delay wraps round to an interval of 65536 external clock ticks
    assign pen_repeat = (sel_reg == SEL_WAIT) && !pen_s2 && ext_tick
                     && (pen_cnt_reg + 16'h0001 == delay_reg);

    always_ff @(posedge CORE_CLK)
    begin
        if (RST || pen_down_edge || pen_repeat || sel_reg != SEL_WAIT)
            pen_cnt_reg <= 16'h0000;
        else if (ext_tick && !pen_s2)
            pen_cnt_reg <= pen_cnt_reg + 16'h0001;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            irq_reg <= 1'b0;
        else
            irq_reg <= (finish && pos_run_reg) // see R26
                    || pen_down_edge || pen_repeat; // see R17
    end

    // channel follows the measurement in progress
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            chan_out_reg <= CONTROL_RESET[CHAN_MSB:CHAN_LSB];
        else if (!pos_run_reg)
            chan_out_reg <= chan_reg;
        else if (ptr_y_reg)
            chan_out_reg <= CHAN_X_PLUS; // see R4
        else
            chan_out_reg <= CHAN_Y_PLUS;
    end

    assign ADC_IRQ        = irq_reg;
    assign ADC_CLK_TICK   = conv_tick;
    assign ADC_CHANNEL    = chan_out_reg;
    assign ADC_CONVERTING = (state_reg == ST_CONV);
    assign ADC_STANDBY    = standby_reg;
    assign Y_RESULT       = y_data_reg;
    assign PANEL_SWITCH.y_minus_switch_signal  = sw_reg[YM_BIT]; // see R8
    assign PANEL_SWITCH.y_plus_switch_signal_n = sw_reg[YP_BIT]; // see R9
    assign PANEL_SWITCH.x_minus_switch_signal  = sw_reg[XM_BIT]; // see R8
    assign PANEL_SWITCH.x_plus_switch_signal_n = sw_reg[XP_BIT]; // see R9
    assign PANEL_SWITCH.x_pullup_n             = sw_reg[PULLUP_BIT]; // see R10

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    sequence s_launch;
        launch;
    endsequence

    sequence s_auto_end;
        end_auto ##1 1'b1;
    endsequence

    a_done_launch: assert property (s_launch |=> !done_reg) // see R27
        else $error("done flag not cleared at launch");
    a_divider_gate: assert property (!div_en_reg ##1 !div_en_reg
        |-> !conv_tick) // see R2
        else $error("converter tick while divider disabled");
    a_five_ticks: assert property (capture |-> conv_tick
        && conv_cnt_reg == 3'h4) // see R24
        else $error("capture not on fifth converter tick");
    a_standby_hold: assert property (standby_reg |=> $stable(x_data_reg)
        && state_reg == ST_IDLE) // see R25
        else $error("standby did not halt conversion");
    a_irq_position: assert property (finish && pos_run_reg // see R26
        |=> ADC_IRQ)
        else $error("no interrupt after position conversion");
    a_auto_pointer: assert property (s_auto_end and (!wr_sw [*2])
        |-> sel_reg == SEL_Y && !auto_reg) // see R13
        else $error("pointer not left at Y after auto sequence");
    a_start_clear: assert property (s_launch and (!wr_ctrl)
        |=> !start_reg) // see R7
        else $error("start bit not cleared at start-up");
    a_stylus_irq: assert property (pen_down_edge |=> ADC_IRQ) // see R17
        else $error("stylus down raised no interrupt");
    a_y_channel: assert property (state_reg == ST_CONV && pos_run_reg
        && ptr_y_reg |=> ADC_CHANNEL == CHAN_X_PLUS) // see R4
        else $error("Y measurement not on X-plus input");
    a_ym_switch: assert property ($rose(sw_reg[YM_BIT])
        |-> PANEL_SWITCH.y_minus_switch_signal) // see R8
        else $error("Y-minus switch not following its bit");

endmodule : adc_touch_panel_control

// [adc_touch_pkg.sv]
package adc_touch_pkg;

    // register byte addresses on the peripheral bus
    localparam logic [31:0] CONVERTER_CONTROL_ADDR    = 32'h4580_0000;
    localparam logic [31:0] PANEL_SWITCH_CONTROL_ADDR = 32'h4580_0004;
    localparam logic [31:0] CONVERSION_DELAY_ADDR     = 32'h4580_0008;
    localparam logic [31:0] X_RESULT_ADDR             = 32'h4580_000C;

    // converter_control fields
    localparam int DONE_BIT       = 15;
    localparam int DIV_EN_BIT     = 14;
    localparam int DIV_VAL_MSB    = 13;
    localparam int DIV_VAL_LSB    = 6;
    localparam int CHAN_MSB       = 5;
    localparam int CHAN_LSB       = 3;
    localparam int STANDBY_BIT    = 2;
    localparam int READ_START_BIT = 1;
    localparam int START_BIT      = 0;

    // panel_switch_control fields
    localparam int YM_BIT         = 7;
    localparam int YP_BIT         = 6;
    localparam int XM_BIT         = 5;
    localparam int XP_BIT         = 4;
    localparam int PULLUP_BIT     = 3;
    localparam int AUTO_BIT       = 2;
    localparam int SEL_MSB        = 1;
    localparam int SEL_LSB        = 0;

    // x_result fields
    localparam int XR_STYLUS_BIT  = 15;
    localparam int XR_AUTO_BIT    = 14;
    localparam int XR_SEL_MSB     = 13;
    localparam int XR_SEL_LSB     = 12;
    localparam int XR_DATA_MSB    = 9;

    // reset values
    localparam logic [15:0] CONTROL_RESET = 16'h3FC4;
    localparam logic [11:0] SWITCH_RESET  = 12'h058;
    localparam logic [15:0] DELAY_RESET   = 16'h00FF;

    // converter clocks per 10-bit conversion
    localparam logic [2:0]  CONV_CYCLES   = 3'h5;
    localparam int          RESULT_W      = 10;

    // panel inputs used by the position measurements
    localparam logic [2:0]  CHAN_Y_PLUS   = 3'h5;
    localparam logic [2:0]  CHAN_X_PLUS   = 3'h7;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_X    = 2'h1,
        SEL_Y    = 2'h2,
        SEL_WAIT = 2'h3
    } meas_sel_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DELAY = 3'h2,
        ST_CONV  = 3'h4
    } conv_state_t;

    typedef struct packed {
        logic y_minus_switch_signal;
        logic y_plus_switch_signal_n;
        logic x_minus_switch_signal;
        logic x_plus_switch_signal_n;
        logic x_pullup_n;
    } panel_switch_t;

endpackage : adc_touch_pkg

// [test_adc_touch_panel_control.sv]
`timescale 1ns/10ps
module test_adc_touch_panel_control
    import adc_touch_pkg::*;
;
    logic        CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [31:0] PADDR, PWDATA, PRDATA, rd;
    logic        ext_clk, stylus_up, pen_down, tick, conv, stby, irq, err;
    logic [2:0]  chan;
    logic [9:0]  res, y_res;
    panel_switch_t sw;
    int          error_cnt, total_checks, cycles, conv_ticks;

    adc_touch_panel_control u_adc_touch_panel_control (
        .CORE_CLK(CORE_CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EXTERNAL_CLOCK_INPUT(ext_clk), .STYLUS_UP(stylus_up),
        .ADC_RESULT(res), .ADC_CLK_TICK(tick), .ADC_CHANNEL(chan),
        .ADC_CONVERTING(conv), .ADC_STANDBY(stby), .PANEL_SWITCH(sw),
        .Y_RESULT(y_res), .ADC_IRQ(irq));

    adc_panel_model u_adc_panel_model (
        .clk(CORE_CLK), .pen_down(pen_down), .channel(chan),
        .ext_clk(ext_clk), .stylus_up(stylus_up), .result(res));

    // converter ticks seen inside a conversion, five per result
    always @(posedge CORE_CLK)
    begin
        if (conv && tick)
            conv_ticks++;
    end

    initial
    begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        rd      = PRDATA;
        err     = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, CONVERTER_CONTROL_ADDR, 32'h0);
            n++;
        end
        while (rd[DONE_BIT] !== 1'b1 && n < 100);
    endtask : wait_done

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        chk({31'h0, irq}, 32'h0000_0001);
    endtask : wait_irq

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, pen_down} = '0;
        RST = 1'b1;
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        apb(1'b0, CONVERTER_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_3FC4);
        apb(1'b0, PANEL_SWITCH_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_0058);
        apb(1'b0, CONVERSION_DELAY_ADDR, 32'h0);
        chk(rd, 32'h0000_00FF);
        chk(32'(sw), 32'h0000_000B);
        apb(1'b0, 32'h4580_0010, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("test reset done");
        apb(1'b1, CONVERSION_DELAY_ADDR, 32'h0000_0002);
        // divide by six: a fifth of core rate exactly would break the limit
        apb(1'b1, CONVERTER_CONTROL_ADDR, 32'h0000_4159);
        wait_done();
        chk(rd, 32'h0000_C158);
        chk(conv_ticks, 32'h0000_0005);
        apb(1'b0, X_RESULT_ADDR, 32'h0);
        chk(rd, 32'h0000_81AB);
        $display("test normal done");
        apb(1'b1, PANEL_SWITCH_CONTROL_ADDR, 32'h0000_0059);
        apb(1'b1, CONVERTER_CONTROL_ADDR, 32'h0000_4141);
        wait_irq();
        apb(1'b0, X_RESULT_ADDR, 32'h0);
        chk(rd, 32'h0000_92AB);
        $display("test x done");
        apb(1'b1, PANEL_SWITCH_CONTROL_ADDR, 32'h0000_005C);
        apb(1'b1, CONVERTER_CONTROL_ADDR, 32'h0000_4141);
        wait_irq();
        chk({22'h0, y_res}, 32'h0000_03AB);
        apb(1'b0, X_RESULT_ADDR, 32'h0);
        chk(rd, 32'h0000_A2AB);
        apb(1'b0, PANEL_SWITCH_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_005A);
        $display("test auto done");
        // normal mode here, so there is no auto bit to re-arm
        apb(1'b1, PANEL_SWITCH_CONTROL_ADDR, 32'h0000_0058);
        apb(1'b1, CONVERTER_CONTROL_ADDR, 32'h0000_4142);
        apb(1'b0, X_RESULT_ADDR, 32'h0);
        apb(1'b0, CONVERTER_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0000_4142);
        wait_done();
        chk(rd, 32'h0000_C142);
        chk(conv_ticks, 32'h0000_0019);
        $display("test read start done");
        apb(1'b1, PANEL_SWITCH_CONTROL_ADDR, 32'h0000_0050);
        apb(1'b1, PANEL_SWITCH_CONTROL_ADDR, 32'h0000_0053);
        pen_down <= 1'b1;
        wait_irq();
        apb(1'b0, X_RESULT_ADDR, 32'h0);
        chk(rd & 32'h0000_8000, 32'h0);
        pen_down <= 1'b0;
        apb(1'b1, CONVERTER_CONTROL_ADDR, 32'h0000_4145);
        // the write lands at the access edge; look once it has settled
        @(negedge CORE_CLK);
        chk({31'h0, stby}, 32'h0000_0001);
        chk({31'h0, conv}, 32'h0000_0000);
        $display("test stylus and standby done");
        complete_run();
    end
endmodule : test_adc_touch_panel_control
